// [logic/pmsc_ctrl.v]
// PHY management serial controller: polling engine, two user slots, clock divider.
// Assumes a 20 MHz clk and a PHY bus with a pull-up on the data wire.
`timescale 1ns/100ps
`include "pmsc_map.vh"
module pmsc_ctrl (
  clk,
  resetn,
  enable,
  preamble_off,
  bus_clock_divider,
  monitored_phy_addr,
  state_change_irq_en,
  state_change_clear,
  slot_load,
  slot_write_in,
  slot_phy_in,
  slot_reg_in,
  slot_data_in,
  request_done_clear,
  request_done_mask_set,
  request_done_mask_clear,
  mdc,
  mdio_out,
  mdio_oe_n,
  mdio_in,
  user_request_slot_busy,
  slot_ack,
  slot_data,
  presence,
  up_state,
  state_change_irq_raw,
  state_change_irq_masked,
  request_done_raw,
  request_done_masked,
  request_done_mask,
  irq
);
  input wire clk;
  input wire resetn;
  input wire enable;
  input wire preamble_off;
  input wire [7:0] bus_clock_divider;
  input wire [4:0] monitored_phy_addr;
  input wire state_change_irq_en;
  input wire state_change_clear;
  input wire [1:0] slot_load;
  input wire [1:0] slot_write_in;
  input wire [9:0] slot_phy_in;
  input wire [9:0] slot_reg_in;
  input wire [31:0] slot_data_in;
  input wire [1:0] request_done_clear;
  input wire [1:0] request_done_mask_set;
  input wire [1:0] request_done_mask_clear;
  output reg mdc;
  output reg mdio_out;
  output reg mdio_oe_n;
  input wire mdio_in;
  output reg [1:0] user_request_slot_busy;
  output reg [1:0] slot_ack;
  output reg [31:0] slot_data;
  output reg [31:0] presence;
  output reg [31:0] up_state;
  output reg state_change_irq_raw;
  output reg state_change_irq_masked;
  output reg [1:0] request_done_raw;
  output reg [1:0] request_done_masked;
  output reg [1:0] request_done_mask;
  output reg irq;

  wire mdio_level;
  reg [7:0] div_cnt;
  reg [1:0] state;
  reg [63:0] shift;
  reg [6:0] cnt;
  reg [6:0] len;
  reg [6:0] off;
  reg cur_user;
  reg cur_slot;
  reg cur_write;
  reg [4:0] cur_phy;
  reg [4:0] poll_addr;
  reg rr_last;
  reg answered;
  reg [15:0] rd_data;
  reg [9:0] slot_reg;
  reg [1:0] slot_write;
  reg [1:0] next_raw;
  reg [1:0] next_mask;
  reg next_link_raw;
  reg link_change;

  pmsc_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_in(mdio_in),
    .level(mdio_level)
  );

  wire [7:0] eff_div = (bus_clock_divider < `PMSC_MIN_DIV) ? `PMSC_MIN_DIV : bus_clock_divider;
  wire tick = (div_cnt >= eff_div);
  wire fall = tick & mdc;
  wire [6:0] fpos = cnt - off;
  wire [6:0] cur_fpos = cnt - off - 7'h01;
  wire pick = (user_request_slot_busy == 2'h3) ? ~rr_last : user_request_slot_busy[1];
  wire any_user = |user_request_slot_busy;
  wire sel_write = slot_write[pick];
  reg [9:0] slot_phy_in_hold;
  wire [4:0] sel_phy = pick ? slot_phy_in_hold[9:5] : slot_phy_in_hold[4:0];
  wire [4:0] sel_reg = pick ? slot_reg[9:5] : slot_reg[4:0];
  wire [15:0] sel_data = pick ? slot_data[31:16] : slot_data[15:0];
  wire [4:0] f_phy = any_user ? sel_phy : poll_addr;
  wire [4:0] f_reg = any_user ? sel_reg : `PMSC_POLL_REG;
  wire f_write = any_user & sel_write;
  wire [31:0] frame = {`PMSC_START, f_write ? `PMSC_OP_WRITE : `PMSC_OP_READ, f_phy, f_reg,
                       `PMSC_TA_WRITE, f_write ? sel_data : 16'hffff};
  wire new_up = answered & rd_data[`PMSC_LINK_BIT];

  // Clock divider; the clock rests low only while no frame runs and enable is low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 8'h00;
      mdc <= 1'b0;
    end else if (tick) begin
      div_cnt <= 8'h00;
      mdc <= (state != `PMSC_ST_IDLE) | enable ? ~mdc : 1'b0;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always @* begin
    next_mask = (request_done_mask | request_done_mask_set) & ~request_done_mask_clear;
    // Hardware set wins over a software clear in the same cycle
    next_raw = request_done_raw & ~request_done_clear;
    next_link_raw = state_change_irq_raw & ~state_change_clear;
    link_change = 1'b0;
    if (state == `PMSC_ST_DONE) begin
      if (cur_user) begin
        next_raw[cur_slot] = 1'b1;
      end else if (poll_addr == monitored_phy_addr && new_up != up_state[poll_addr]) begin
        link_change = 1'b1;
      end
    end
    if (link_change && state_change_irq_en) begin
      next_link_raw = 1'b1;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= `PMSC_ST_IDLE;
      shift <= 64'h0;
      cnt <= 7'h00;
      len <= 7'h00;
      off <= 7'h00;
      cur_user <= 1'b0;
      cur_slot <= 1'b0;
      cur_write <= 1'b0;
      cur_phy <= 5'h00;
      poll_addr <= 5'h00;
      rr_last <= 1'b1;
      answered <= 1'b0;
      rd_data <= 16'h0000;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
      user_request_slot_busy <= 2'h0;
      slot_ack <= 2'h0;
      slot_data <= 32'h0;
      slot_reg <= 10'h0;
      slot_write <= 2'h0;
      slot_phy_in_hold <= 10'h0;
      presence <= 32'h0;
      up_state <= 32'h0;
      state_change_irq_raw <= 1'b0;
      state_change_irq_masked <= 1'b0;
      request_done_raw <= 2'h0;
      request_done_masked <= 2'h0;
      request_done_mask <= 2'h0;
      irq <= 1'b0;
    end else begin
      request_done_raw <= next_raw;
      request_done_mask <= next_mask;
      request_done_masked <= next_raw & next_mask;
      irq <= |(next_raw & next_mask);
      state_change_irq_raw <= next_link_raw;
      state_change_irq_masked <= next_link_raw & state_change_irq_en;
      // a slot takes all its fields in one load
      if (slot_load[0] && !user_request_slot_busy[0]) begin
        user_request_slot_busy[0] <= 1'b1;
        slot_write[0] <= slot_write_in[0];
        slot_phy_in_hold[4:0] <= slot_phy_in[4:0];
        slot_reg[4:0] <= slot_reg_in[4:0];
        slot_data[15:0] <= slot_data_in[15:0];
        slot_ack[0] <= 1'b0;
      end
      if (slot_load[1] && !user_request_slot_busy[1]) begin
        user_request_slot_busy[1] <= 1'b1;
        slot_write[1] <= slot_write_in[1];
        slot_phy_in_hold[9:5] <= slot_phy_in[9:5];
        slot_reg[9:5] <= slot_reg_in[9:5];
        slot_data[31:16] <= slot_data_in[31:16];
        slot_ack[1] <= 1'b0;
      end
      case (state)
        `PMSC_ST_IDLE: begin
          if (enable && fall) begin
            shift <= preamble_off ? {frame, 32'h0} : {32'hffffffff, frame};
            off <= preamble_off ? 7'h00 : `PMSC_PRE_BITS;
            len <= preamble_off ? `PMSC_FRAME_BITS : `PMSC_PRE_BITS + `PMSC_FRAME_BITS;
            cur_user <= any_user;
            cur_slot <= pick;
            cur_write <= f_write;
            cur_phy <= f_phy;
            if (any_user) begin
              rr_last <= pick;
            end
            answered <= 1'b0;
            cnt <= 7'h00;
            state <= `PMSC_ST_SHIFT;
          end
        end
        `PMSC_ST_SHIFT: begin
          if (fall) begin
            // read bits taken at bit end
            // The synchroniser needs four clocks, so the rising tick would be too early
            if (!cur_write && cnt > off) begin
              if (cur_fpos == `PMSC_TA_ACK_POS) begin
                answered <= ~mdio_level;
              end
              if (cur_fpos >= `PMSC_DATA_POS) begin
                rd_data <= {rd_data[14:0], mdio_level};
              end
            end
            if (cnt == len) begin
              mdio_oe_n <= 1'b1;
              mdio_out <= 1'b1;
              state <= `PMSC_ST_DONE;
            end else begin
              // drive the data wire on the falling edge
              mdio_out <= shift[63];
              mdio_oe_n <= ~(cur_write || cnt < off || fpos <= `PMSC_LAST_DRIVEN_RD);
              shift <= {shift[62:0], 1'b0};
              cnt <= cnt + 7'h01;
            end
          end
        end
        `PMSC_ST_DONE: begin
          state <= `PMSC_ST_IDLE;
          if (cur_user) begin
            user_request_slot_busy[cur_slot] <= 1'b0;
            if (!cur_write) begin
              slot_ack[cur_slot] <= answered;
              if (cur_slot) begin
                slot_data[31:16] <= rd_data;
              end else begin
                slot_data[15:0] <= rd_data;
              end
              presence[cur_phy] <= answered;
            end
          end else begin
            presence[poll_addr] <= answered;
            // up state needs an answer and a connection
            up_state[poll_addr] <= new_up;
            poll_addr <= poll_addr + 5'h01;
          end
        end
        default: begin
          state <= `PMSC_ST_IDLE;
        end
      endcase
    end
  end
endmodule // pmsc_ctrl

// [shared/pmsc_map.vh]
// Constants for the PHY management serial controller.
// Assumes a 20 MHz system clock and clause 22 management frames.
`ifndef PMSC_MAP_VH
`define PMSC_MAP_VH

// Clock figures in kHz; the management clock may not exceed its maximum
`define PMSC_CLK_KHZ 20000
`define PMSC_MDC_MAX_KHZ 2500
// Least half period in system clocks, rounded up
`define PMSC_MIN_HALF ((`PMSC_CLK_KHZ + 2 * `PMSC_MDC_MAX_KHZ - 1) / (2 * `PMSC_MDC_MAX_KHZ))
`define PMSC_MIN_DIV 8'h03

// Frame layout, bit positions counted after the preamble
`define PMSC_PRE_BITS 7'h20
`define PMSC_FRAME_BITS 7'h20
`define PMSC_LAST_DRIVEN_RD 7'h0d
`define PMSC_TA_ACK_POS 7'h0f
`define PMSC_DATA_POS 7'h10
`define PMSC_START 2'h1
`define PMSC_OP_WRITE 2'h1
`define PMSC_OP_READ 2'h2
`define PMSC_TA_WRITE 2'h2

// Polled generic status register and its connection bit
`define PMSC_POLL_REG 5'h01
`define PMSC_LINK_BIT 2

// Engine states
`define PMSC_ST_IDLE 2'h0
`define PMSC_ST_SHIFT 2'h1
`define PMSC_ST_DONE 2'h2

`endif

// [logic/pmsc_sync.v]
// Three-flop synchroniser for the management data input pin.
// Assumes the pin idles high through its pull-up.
`timescale 1ns/100ps
module pmsc_sync (
  clk,
  resetn,
  pin_in,
  level
);
  input wire clk;
  input wire resetn;
  input wire pin_in;
  output reg level;

  reg s1;
  reg s2;
  reg s3;

  // A change counts only when the second and third stages agree
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level <= 1'b1;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule // pmsc_sync

// [tb/pmsc_ctrl_monitor.sv]
// Port checks for the management controller.
// Assumes it is bound into every pmsc_ctrl instance.
`timescale 1ns/100ps
module pmsc_ctrl_monitor (
  input wire clk, resetn, mdc, state_change_irq_en, state_change_irq_raw,
  input wire [1:0] slot_load, user_request_slot_busy, slot_ack,
  input wire [1:0] request_done_raw, request_done_mask, request_done_masked
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [1:0] bsy = user_request_slot_busy;
  sequence s_take0;
    slot_load[0] && !bsy[0];
  endsequence
  sequence s_end1;
    $fell(bsy[1]);
  endsequence
  load_starts_a: assert property (s_take0 |=> bsy[0])
    else $error("slot load not taken");
  busy_cause_a: assert property ($rose(bsy[1]) |-> $past(slot_load[1]))
    else $error("start bit without load");
  done_flag_a: assert property ($fell(bsy[0]) |-> request_done_raw[0])
    else $error("no done flag at completion");
  ack_done_a: assert property ($rose(slot_ack[1]) |-> s_end1)
    else $error("ack outside completion");
  mask_gate_a: assert property ($rose(request_done_masked[1]) |->
    request_done_mask[1] || $past(request_done_mask[1]))
    else $error("masked done while masked off");
  link_flag_a: assert property ($rose(state_change_irq_raw) |->
    state_change_irq_en || $past(state_change_irq_en))
    else $error("change flag while disabled");
  mdc_high_a: assert property ($rose(mdc) |-> mdc[*4])
    else $error("bus clock high too short");
  mdc_low_a: assert property ($fell(mdc) |-> !mdc[*4])
    else $error("bus clock low too short");
endmodule // pmsc_ctrl_monitor

bind pmsc_ctrl pmsc_ctrl_monitor u_mon (.clk, .resetn, .mdc, .state_change_irq_en,
  .state_change_irq_raw, .slot_load, .user_request_slot_busy, .slot_ack, .request_done_raw,
  .request_done_mask, .request_done_masked);

// [tb/pmsc_phy_model.sv]
// Behavioural PHY answering at one management address.
// Assumes a pull-up on the data wire, so a release reads as 1.
`timescale 1ns/100ps
module pmsc_phy_model #(parameter [4:0] ADDR = 5'h05) (
  input wire mdc, mdio, link_up,
  output reg drive_en = 1'b0,
  output reg drive_bit = 1'b1
);
  reg [15:0] regs [0:31];
  reg [13:0] hdr = 14'h3fff;
  reg [15:0] sh;
  integer cnt = 0, k;
  wire rd = hdr[11:10] == 2'h2 && hdr[9:5] == ADDR;
  wire [15:0] rv = hdr[4:0] == 5'h01 ? {regs[1][15:3], link_up, regs[1][1:0]} : regs[hdr[4:0]];
  initial for (k = 0; k < 32; k = k + 1) regs[k] = 16'h0000;
  always @(posedge mdc) begin
    if (cnt == 32) begin
      cnt = 0;
      hdr = 14'h3fff;
    end
    if (cnt < 14) hdr = {hdr[12:0], mdio};
    if (cnt == 0)
      cnt = hdr[1:0] == 2'b01 ? 2 : 0;
    else
      cnt = cnt + 1;
    if (cnt > 16) sh = {sh[14:0], mdio};
    if (cnt == 32 && hdr[11:10] == 2'h1 && hdr[9:5] == ADDR) regs[hdr[4:0]] = sh;
  end
  always @(negedge mdc) begin
    drive_en <= rd && cnt > 14 && cnt < 32;
    drive_bit <= cnt == 15 ? 1'b0 : rv[(31 - cnt) & 15];
  end
endmodule // pmsc_phy_model

// [tb/tb.sv]
// Self-checking bench for the PHY management serial controller.
// Assumes the PHY model and the port monitor are compiled first.
`timescale 1ns/100ps
module tb;
  localparam [4:0] PA = 5'h05;
  reg clk = 0, resetn = 0, enable = 0, link = 1;
  reg [4:0] monitored_phy_addr = 5'h00;
  reg [1:0] slot_load = 0, slot_write_in = 0;
  reg [1:0] request_done_mask_set = 0, request_done_mask_clear = 0;
  reg [9:0] slot_phy_in = 0, slot_reg_in = 0;
  reg [31:0] slot_data_in = 0, acc;
  wire mdc, mdio_out, mdio_oe_n, ph_en, ph_bit, sc_raw, sc_m, irq;
  wire [1:0] busy, slot_ack, draw, dmsk, mask;
  wire [31:0] slot_data, presence, up_state;
  wire mdio = !mdio_oe_n ? mdio_out : (ph_en ? ph_bit : 1'b1);
  integer n_mismatch = 0, n_checks = 0, i;
  // preamble and divider fixed before enable
  pmsc_ctrl u_dut (.clk, .resetn, .enable, .preamble_off(1'b0), .bus_clock_divider(8'h03),
    .monitored_phy_addr, .state_change_irq_en(1'b1), .state_change_clear(1'b0), .slot_load,
    .slot_write_in, .slot_phy_in, .slot_reg_in, .slot_data_in, .request_done_clear(2'h0),
    .request_done_mask_set, .request_done_mask_clear, .mdc, .mdio_out, .mdio_oe_n,
    .mdio_in(mdio), .user_request_slot_busy(busy), .slot_ack, .slot_data, .presence, .up_state,
    .state_change_irq_raw(sc_raw), .state_change_irq_masked(sc_m), .request_done_raw(draw),
    .request_done_masked(dmsk), .request_done_mask(mask), .irq);
  pmsc_phy_model #(.ADDR(PA)) u_phy (.mdc, .mdio, .link_up(link), .drive_en(ph_en),
    .drive_bit(ph_bit));
  initial forever #25 clk = ~clk;
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // all fields staged for one load
  task set_req(input integer s, input w, input [4:0] pa, input [4:0] ra, input [15:0] d);
    begin
      slot_write_in[s] <= w;
      slot_phy_in[s*5 +: 5] <= pa;
      slot_reg_in[s*5 +: 5] <= ra;
      slot_data_in[s*16 +: 16] <= d;
    end
  endtask
  // poll start bits mid-cycle, away from the edge
  task wait_free;
    begin
      for (i = 0; i < 3000 && busy !== 2'b00; i = i + 1)
        @(negedge clk);
      @(posedge clk);
    end
  endtask
  task req(input integer s, input w, input [4:0] pa, input [4:0] ra, input [15:0] d);
    begin
      set_req(s, w, pa, ra, d);
      slot_load[s] <= 1'b1;
      cyc(1);
      slot_load <= 2'b00;
      cyc(1);
      wait_free;
    end
  endtask
  task t_idle;
    begin
      cyc(40);
      chk({mdc, mdio_oe_n, mdio_out, busy}, 5'b01100, "idle pins");
      chk(presence, 32'h0, "idle presence");
      $display("idle done");
    end
  endtask
  task t_poll;
    begin
      enable <= 1'b1;
      // Two idle clock pulses come before the first preamble bit
      for (i = 0; i < 35; i = i + 1) begin
        @(posedge mdc);
        if (i == 34) begin
          chk(acc, 32'hffffffff, "preamble");
          chk(mdio, 1'b0, "start bit");
        end
        acc = {acc[30:0], mdio};
      end
      cyc(16500);
      chk(presence, 32'h1 << PA, "presence");
      chk(up_state, 32'h1 << PA, "up state");
      chk(sc_raw, 1'b0, "unwatched change");
      monitored_phy_addr <= PA;
      link <= 1'b0;
      cyc(16500);
      chk(up_state, 32'h0, "link lost");
      chk({sc_raw, sc_m}, 2'b11, "change flags");
      $display("poll done");
    end
  endtask
  task t_user;
    begin
      request_done_mask_set <= 2'b11;
      cyc(1);
      request_done_mask_set <= 2'b00;
      request_done_mask_clear <= 2'b01;
      cyc(1);
      request_done_mask_clear <= 2'b00;
      req(0, 1'b1, PA, 5'h04, 16'hbeef);
      chk(u_phy.regs[4], 16'hbeef, "written reg");
      chk({mask, dmsk, draw, irq}, 7'b1000010, "write done");
      req(1, 1'b0, PA, 5'h04, 16'h0000);
      chk(slot_data[31:16], 16'hbeef, "read data");
      chk({slot_ack[1], dmsk, draw, irq}, 6'b110111, "read done");
      req(0, 1'b0, 5'h09, 5'h02, 16'h0000);
      chk(slot_ack[0], 1'b0, "absent ack");
      chk(presence, 32'h1 << PA, "user presence");
      $display("user done");
    end
  endtask
  task t_rr;
    begin
      set_req(0, 1'b1, PA, 5'h06, 16'h1234);
      set_req(1, 1'b1, PA, 5'h07, 16'h5678);
      slot_load <= 2'b11;
      cyc(1);
      slot_load <= 2'b00;
      cyc(1);
      for (i = 0; i < 3000 && busy === 2'b11; i = i + 1)
        @(negedge clk);
      chk(busy, 2'b01, "first served");
      wait_free;
      chk(u_phy.regs[7], 16'h5678, "second reg");
      $display("round robin done");
    end
  endtask
  initial begin
    cyc(2);
    resetn <= 1'b1;
    t_idle;
    t_poll;
    t_user;
    t_rr;
    complete_run;
  end
  initial begin
    cyc(60000);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
endmodule // tb
